// ---- rtl/itfm_map.svh ----
`ifndef ITFM_MAP_SVH
`define ITFM_MAP_SVH

// register byte offsets
`define ITFM_OFF_CFG         5'h00
`define ITFM_OFF_FUNC0       5'h04
`define ITFM_OFF_FUNC4       5'h14
`define ITFM_OFF_STATUS      5'h18
`define ITFM_OFF_CMD         5'h1c

// configuration word fields
`define ITFM_CFG_REMOTE_LSB  0
`define ITFM_CFG_REMOTE_W    8
`define ITFM_CFG_SHUT_LSB    8
`define ITFM_CFG_SHUT_W      3
`define ITFM_CFG_OPMODE_LSB  12
`define ITFM_CFG_OPMODE_W    4
`define ITFM_CFG_COMM_BIT    16

// status word fields
`define ITFM_ST_SYNC_LSB     0
`define ITFM_ST_STABLE_LSB   5
`define ITFM_ST_VF_BIT       10
`define ITFM_ST_OUT_EN_BIT   11

// reset values
`define ITFM_RST_CFG         32'h0000_0000
`define ITFM_RST_FUNC0       14'h003c
`define ITFM_RST_FUNC1       14'h003d
`define ITFM_RST_FUNC2       14'h0000
`define ITFM_RST_FUNC3       14'h0001
`define ITFM_RST_FUNC4       14'h0002

// function codes
`define ITFM_CODE_NONE       14'h270f
`define ITFM_CODE_FWD        14'h003c
`define ITFM_CODE_REV        14'h003d

// selector values
`define ITFM_SHUT_NO         3'h0
`define ITFM_SHUT_NC         3'h2
`define ITFM_SHUT_SPLIT      3'h4
`define ITFM_OPMODE_ILOCK    4'h7

// timing
`define ITFM_CLK_KHZ         25000
`define ITFM_FAST_LIMIT_US   2000
`define ITFM_SLOW_LIMIT_US   20000
`define ITFM_SYNC_LATENCY    3

`endif

// ---- rtl/itfm_pkg.sv ----
`include "itfm_map.svh"

package itfm_pkg;

    typedef enum logic [4:0] {
        FN_NONE       = 5'h00,
        FN_LOW        = 5'h01,
        FN_MID        = 5'h02,
        FN_HIGH       = 5'h03,
        FN_RCLR       = 5'h04,
        FN_RDEC       = 5'h05,
        FN_RACC       = 5'h06,
        FN_SECOND     = 5'h07,
        FN_INPUT4     = 5'h08,
        FN_JOG        = 5'h09,
        FN_THERMAL    = 5'h0a,
        FN_FIFTEEN    = 5'h0b,
        FN_RUN_EN     = 5'h0c,
        FN_ILOCK      = 5'h0d,
        FN_LOOP       = 5'h0e,
        FN_PANEL_EXT  = 5'h0f,
        FN_VF         = 5'h10,
        FN_SHUTOFF    = 5'h11,
        FN_SELF_HOLD  = 5'h12,
        FN_TRAVERSE   = 5'h13,
        FN_FWD        = 5'h14,
        FN_REV        = 5'h15,
        FN_RESET      = 5'h16,
        FN_PANEL_NET  = 5'h17,
        FN_EXT_NET    = 5'h18,
        FN_CMD_SRC    = 5'h19
    } itfm_fn_e;

    localparam int ITFM_FN_COUNT = 26;

    typedef enum logic [1:0] {
        SPD_NONE  = 2'h0,
        SPD_JOG   = 2'h1,
        SPD_MULTI = 2'h2,
        SPD_LOOP  = 2'h3
    } itfm_speed_e;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ANSWER = 2'b01
    } itfm_bus_e;

    typedef struct packed {
        logic [`ITFM_CFG_OPMODE_W-1:0] operation_mode_selector;
        logic [`ITFM_CFG_SHUT_W-1:0]   shutoff_logic_selector;
        logic [`ITFM_CFG_REMOTE_W-1:0] remote_setting_selector;
        logic                          comm_shutoff_in;
    } itfm_cfg_s;

    typedef struct packed {
        logic low_speed_cmd;
        logic middle_speed_cmd;
        logic high_speed_cmd;
        logic remote_clear;
        logic remote_decel;
        logic remote_accel;
        logic second_function_select;
        logic input4_select;
        logic voltage_input_valid;
        logic jog_select;
        logic thermal_relay_in;
        logic fifteen_speed_select;
        logic run_enable_in;
        logic panel_interlock_in;
        logic loop_control_enable;
        logic external_mode_sel;
        logic vf_control;
        logic output_shutoff_in;
        logic coast_stop;
        logic start_self_hold;
        logic traverse_select;
        logic forward_run_cmd;
        logic reverse_run_cmd;
        logic drive_reset_in;
        logic panel_mode_sel;
        logic network_mode_sel;
        logic command_source_switch;
    } itfm_cmd_s;

endpackage

// ---- rtl/itfm_filter.sv ----
`timescale 1ns/10ps
`include "itfm_map.svh"

module itfm_filter #(
    parameter int CYCLES = 4
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // contact
    input  wire logic i_raw,
    // conditioned level
    output logic      o_sync,
    output logic      o_stable
);
    localparam int CW = $clog2(CYCLES + 1);

    logic          meta_q;
    logic [CW-1:0] cnt_q;

    initial begin
        if (CYCLES < 1) begin
            $error("itfm_filter: CYCLES must be at least 1");
        end
    end

    // two-stage synchroniser
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_raw;
            o_sync <= meta_q;
        end
    end

    // level is accepted after it stood unchanged for CYCLES clocks
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_q    <= '0;
            o_stable <= 1'b0;
        end else if (o_sync == o_stable) begin
            cnt_q <= '0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            cnt_q    <= '0;
            o_stable <= o_sync;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// ---- rtl/itfm_mapper.sv ----
// Overview of operation
// - each terminal has its own function code
// - codes 0-2 speed, else remote setting
// - code 4 input4 select, voltage input ignored
// - code 7 thermal relay, active when open
// - code 10 run enable, 12 interlock
// - code 14 loop control enable
// - code 16 on selects external mode
// - code 18 on selects fixed V/F control
// - code 65 on selects panel operation
// - code 66 on selects network operation
// - code 67 enables command source selectors
// - forward only terminal 0, reverse terminal 1
// - duplicate assignments are ORed together
// - speed priority jog, multi-speed, loop control
// - shutoff covers missing run enable, interlock in mode 7
// - V/F also selects second set; held running
// - run enable, shutoff 2ms; others 20ms
// - shutoff logic 0 NO, 2 NC, 4 split
// - code 24 shutoff cuts output immediately
// - shutoff blocks start, keeps output off
// - shutoff lets motor coast
// - selection 4 runs only terminal on, comm off
`timescale 1ns/10ps
`include "itfm_map.svh"

module itfm_mapper
    import itfm_pkg::*;
#(
    parameter int TERMINALS       = 5,
    parameter int DEBOUNCE_CYCLES = (`ITFM_SLOW_LIMIT_US * (`ITFM_CLK_KHZ / 1000)) / 2
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    // avalon-mm slave
    input  wire logic [4:0]       i_avs_address,
    input  wire logic             i_avs_read,
    input  wire logic             i_avs_write,
    input  wire logic [31:0]      i_avs_writedata,
    input  wire logic [3:0]       i_avs_byteenable,
    output logic [31:0]           o_avs_readdata,
    output logic                  o_avs_waitrequest,
    // contacts and drive state
    input  wire logic [TERMINALS-1:0] i_terminal,
    input  wire logic             i_running,
    // internal drive signals
    output itfm_cmd_s             o_cmd,
    output itfm_speed_e           o_speed_source,
    output logic [3:0]            o_multi_speed_index,
    output logic                  o_output_enable
);
    localparam int SLOW_LIMIT_CYCLES = `ITFM_SLOW_LIMIT_US * (`ITFM_CLK_KHZ / 1000);
    localparam int FAST_LIMIT_CYCLES = `ITFM_FAST_LIMIT_US * (`ITFM_CLK_KHZ / 1000);

    initial begin
        if (TERMINALS != 5) begin
            $error("itfm_mapper: register map serves exactly five terminals");
        end
        if (DEBOUNCE_CYCLES < 1 ||
            DEBOUNCE_CYCLES + `ITFM_SYNC_LATENCY > SLOW_LIMIT_CYCLES) begin
            $error("itfm_mapper: DEBOUNCE_CYCLES breaks the slow response limit");
        end
        if (`ITFM_SYNC_LATENCY > FAST_LIMIT_CYCLES) begin
            $error("itfm_mapper: sync latency breaks the fast response limit");
        end
    end

    // code legality per terminal; forward and reverse are bound to one terminal each
    function automatic logic code_ok(input logic [13:0] code, input int term);
        code_ok = 1'b0;
        unique case (code)
            14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005,
            14'h0007, 14'h0008, 14'h000a, 14'h000c, 14'h000e, 14'h0010,
            14'h0012, 14'h0018, 14'h0019, 14'h0025, 14'h003e, 14'h0041,
            14'h0042, 14'h0043, `ITFM_CODE_NONE: code_ok = 1'b1;
            `ITFM_CODE_FWD: code_ok = (term == 0);
            `ITFM_CODE_REV: code_ok = (term == 1);
            default: code_ok = 1'b0;
        endcase
    endfunction

    // code to internal function
    function automatic itfm_fn_e decode(input logic [13:0] code, input logic remote);
        decode = FN_NONE;
        unique case (code)
            14'h0000: decode = remote ? FN_RCLR : FN_LOW;
            14'h0001: decode = remote ? FN_RDEC : FN_MID;
            14'h0002: decode = remote ? FN_RACC : FN_HIGH;
            14'h0003: decode = FN_SECOND;
            14'h0004: decode = FN_INPUT4;
            14'h0005: decode = FN_JOG;
            14'h0007: decode = FN_THERMAL;
            14'h0008: decode = FN_FIFTEEN;
            14'h000a: decode = FN_RUN_EN;
            14'h000c: decode = FN_ILOCK;
            14'h000e: decode = FN_LOOP;
            14'h0010: decode = FN_PANEL_EXT;
            14'h0012: decode = FN_VF;
            14'h0018: decode = FN_SHUTOFF;
            14'h0019: decode = FN_SELF_HOLD;
            14'h0025: decode = FN_TRAVERSE;
            `ITFM_CODE_FWD: decode = FN_FWD;
            `ITFM_CODE_REV: decode = FN_REV;
            14'h003e: decode = FN_RESET;
            14'h0041: decode = FN_PANEL_NET;
            14'h0042: decode = FN_EXT_NET;
            14'h0043: decode = FN_CMD_SRC;
            default:  decode = FN_NONE;
        endcase
    endfunction

    // byte-enable merge
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    endfunction

    itfm_cfg_s       cfg_q;
    logic [13:0]     func_q [TERMINALS];
    logic [TERMINALS-1:0] sync_in;
    logic [TERMINALS-1:0] stable_in;
    itfm_bus_e       bus_q;
    logic            vf_q;
    logic [31:0]     rd_d;
    logic [31:0]     cfg_word;
    logic [31:0]     cfg_new;
    logic            wr_take;
    logic [2:0]      func_idx;
    logic [ITFM_FN_COUNT-1:0] fn_slow;
    logic [ITFM_FN_COUNT-1:0] fn_fast;
    logic [ITFM_FN_COUNT-1:0] fn_used;
    logic            remote_on;
    logic            term_shut;
    logic            shut_active;
    logic            run_en;
    logic            ilock;
    itfm_cmd_s       cmd_d;
    itfm_speed_e     spd_d;

    // per-terminal conditioning
    genvar gt;
    generate
        for (gt = 0; gt < TERMINALS; gt++) begin : g_term
            itfm_filter #(
                .CYCLES (DEBOUNCE_CYCLES)
            ) u_filter (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_raw     (i_terminal[gt]),
                .o_sync    (sync_in[gt]),
                .o_stable  (stable_in[gt])
            );
        end
    endgenerate

    // bus handshake: request seen in idle, answered one cycle later
    assign wr_take  = (bus_q == BUS_ANSWER) && i_avs_write;
    assign func_idx = 3'(i_avs_address[4:2] - 3'h1);
    assign cfg_word = {15'h0000, cfg_q.comm_shutoff_in, cfg_q.operation_mode_selector,
                       1'b0, cfg_q.shutoff_logic_selector, cfg_q.remote_setting_selector};
    assign cfg_new  = merge(cfg_word, i_avs_writedata, i_avs_byteenable);

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (i_avs_address)
            `ITFM_OFF_CFG: rd_d = cfg_word;
            5'h04, 5'h08, 5'h0c, 5'h10, `ITFM_OFF_FUNC4:
                rd_d = {18'h00000, func_q[func_idx]};
            `ITFM_OFF_STATUS: begin
                rd_d[`ITFM_ST_SYNC_LSB +: 5]   = sync_in;
                rd_d[`ITFM_ST_STABLE_LSB +: 5] = stable_in;
                rd_d[`ITFM_ST_VF_BIT]          = vf_q;
                rd_d[`ITFM_ST_OUT_EN_BIT]      = o_output_enable;
            end
            `ITFM_OFF_CMD: rd_d = {5'h00, o_cmd};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            bus_q             <= BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            unique case (bus_q)
                BUS_IDLE: if (i_avs_read || i_avs_write) begin
                    bus_q             <= BUS_ANSWER;
                    o_avs_waitrequest <= 1'b0;
                    o_avs_readdata    <= i_avs_read ? rd_d : 32'h0000_0000;
                end
                BUS_ANSWER: begin
                    bus_q             <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_q             <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // configuration register
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cfg_q <= '0;
        end else if (wr_take && i_avs_address == `ITFM_OFF_CFG) begin
            cfg_q.remote_setting_selector <= cfg_new[`ITFM_CFG_REMOTE_LSB +: `ITFM_CFG_REMOTE_W];
            cfg_q.shutoff_logic_selector  <= cfg_new[`ITFM_CFG_SHUT_LSB +: `ITFM_CFG_SHUT_W];
            cfg_q.operation_mode_selector <= cfg_new[`ITFM_CFG_OPMODE_LSB +: `ITFM_CFG_OPMODE_W];
            cfg_q.comm_shutoff_in         <= cfg_new[`ITFM_CFG_COMM_BIT];
        end
    end

    // function code registers; an illegal code leaves the old one in place
    generate
        for (gt = 0; gt < TERMINALS; gt++) begin : g_func
            logic [13:0] rst_code;
            logic [31:0] new_code;
            assign rst_code = (gt == 0) ? `ITFM_RST_FUNC0 : (gt == 1) ? `ITFM_RST_FUNC1 :
                              (gt == 2) ? `ITFM_RST_FUNC2 : (gt == 3) ? `ITFM_RST_FUNC3 :
                              `ITFM_RST_FUNC4;
            assign new_code = merge({18'h00000, func_q[gt]}, i_avs_writedata, i_avs_byteenable);
            always_ff @(posedge i_sys_clk) begin
                if (!i_reset_n) begin
                    // each terminal wakes with its own default code
                    func_q[gt] <= rst_code;
                end else if (wr_take && i_avs_address == 5'(`ITFM_OFF_FUNC0 + 4 * gt) &&
                             code_ok(new_code[13:0], gt)) begin
                    func_q[gt] <= new_code[13:0];
                end
            end
        end
    endgenerate

    // merge terminals into internal signals
    assign remote_on = (cfg_q.remote_setting_selector != 8'h00);

    always_comb begin
        itfm_fn_e f;
        f       = FN_NONE;
        fn_slow = '0;
        fn_fast = '0;
        fn_used = '0;
        for (int t = 0; t < TERMINALS; t++) begin
            f = decode(func_q[t], remote_on);
            fn_used[f] = 1'b1;
            if (f == FN_THERMAL) begin
                fn_slow[f] = fn_slow[f] | ~stable_in[t];
            end else begin
                fn_slow[f] = fn_slow[f] | stable_in[t];
            end
            fn_fast[f] = fn_fast[f] | sync_in[t];
        end
        fn_used[FN_NONE] = 1'b0;
        fn_slow[FN_NONE] = 1'b0;
        fn_fast[FN_NONE] = 1'b0;
    end

    // shutoff logic selection
    always_comb begin
        term_shut = fn_fast[FN_SHUTOFF];
        unique case (cfg_q.shutoff_logic_selector)
            `ITFM_SHUT_NC:    shut_active = !(term_shut && cfg_q.comm_shutoff_in);
            `ITFM_SHUT_SPLIT: shut_active = !(term_shut && !cfg_q.comm_shutoff_in);
            default:          shut_active = term_shut || cfg_q.comm_shutoff_in;
        endcase
    end

    // missing run enable, or missing interlock in operation mode 7, is taken over by the shutoff input
    assign run_en = fn_used[FN_RUN_EN] ? fn_fast[FN_RUN_EN] : !shut_active;
    assign ilock  = (!fn_used[FN_ILOCK] &&
                     cfg_q.operation_mode_selector == `ITFM_OPMODE_ILOCK) ?
                    shut_active : fn_slow[FN_ILOCK];

    // control method follows the switch only while stopped
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            vf_q <= 1'b0;
        end else if (!i_running) begin
            vf_q <= fn_slow[FN_VF];
        end
    end

    always_comb begin
        cmd_d = '0;
        cmd_d.low_speed_cmd          = fn_slow[FN_LOW];
        cmd_d.middle_speed_cmd       = fn_slow[FN_MID];
        cmd_d.high_speed_cmd         = fn_slow[FN_HIGH];
        cmd_d.remote_clear           = fn_slow[FN_RCLR];
        cmd_d.remote_decel           = fn_slow[FN_RDEC];
        cmd_d.remote_accel           = fn_slow[FN_RACC];
        cmd_d.second_function_select = fn_slow[FN_SECOND] || fn_slow[FN_VF];
        cmd_d.input4_select          = fn_slow[FN_INPUT4];
        cmd_d.voltage_input_valid    = !fn_slow[FN_INPUT4];
        cmd_d.jog_select             = fn_slow[FN_JOG];
        cmd_d.thermal_relay_in       = fn_slow[FN_THERMAL];
        cmd_d.fifteen_speed_select   = fn_slow[FN_FIFTEEN];
        cmd_d.run_enable_in          = run_en;
        cmd_d.panel_interlock_in     = ilock;
        cmd_d.loop_control_enable    = fn_slow[FN_LOOP];
        cmd_d.external_mode_sel      = fn_slow[FN_PANEL_EXT];
        cmd_d.vf_control             = vf_q;
        cmd_d.output_shutoff_in      = shut_active;
        cmd_d.coast_stop             = shut_active;
        cmd_d.start_self_hold        = fn_slow[FN_SELF_HOLD];
        cmd_d.traverse_select        = fn_slow[FN_TRAVERSE];
        cmd_d.forward_run_cmd        = fn_slow[FN_FWD] && !shut_active;
        cmd_d.reverse_run_cmd        = fn_slow[FN_REV] && !shut_active;
        cmd_d.drive_reset_in         = fn_slow[FN_RESET];
        cmd_d.panel_mode_sel         = fn_slow[FN_PANEL_NET];
        cmd_d.network_mode_sel       = fn_slow[FN_EXT_NET];
        cmd_d.command_source_switch  = fn_slow[FN_CMD_SRC];
    end

    // speed source arbitration
    always_comb begin
        if (fn_slow[FN_JOG]) begin
            spd_d = SPD_JOG;
        end else if (fn_slow[FN_LOW] || fn_slow[FN_MID] || fn_slow[FN_HIGH] ||
                     fn_slow[FN_FIFTEEN]) begin
            spd_d = SPD_MULTI;
        end else if (fn_slow[FN_LOOP]) begin
            spd_d = SPD_LOOP;
        end else begin
            spd_d = SPD_NONE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_cmd               <= '0;
            o_speed_source      <= SPD_NONE;
            o_multi_speed_index <= 4'h0;
            o_output_enable     <= 1'b0;
        end else begin
            o_cmd               <= cmd_d;
            o_speed_source      <= spd_d;
            o_multi_speed_index <= {fn_slow[FN_FIFTEEN], fn_slow[FN_HIGH],
                                    fn_slow[FN_MID], fn_slow[FN_LOW]};
            o_output_enable     <= !shut_active && run_en;
        end
    end
endmodule

// ---- test/itfm_contacts.sv ----
`timescale 1ns/10ps
module itfm_contacts (
    // clock
    input  wire logic       i_clk,
    // wanted contact states
    input  wire logic [4:0] i_closed,
    // contact levels, 1 = closed
    output logic      [4:0] o_terminal
);
    // contacts move only just after a clock edge, like a relay card
    always @(posedge i_clk) begin
        o_terminal <= i_closed;
    end
endmodule

// ---- test/itfm_mapper_checker.sv ----
`timescale 1ns/10ps
module itfm_mapper_checker
    import itfm_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    input wire logic [4:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic        i_running,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire itfm_cmd_s   o_cmd,
    input wire itfm_speed_e o_speed_source,
    input wire logic        o_output_enable
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    wire req   = i_avs_read | i_avs_write;
    wire shut  = o_cmd.output_shutoff_in;
    wire jog   = o_cmd.jog_select;
    wire multi = o_cmd.low_speed_cmd | o_cmd.middle_speed_cmd | o_cmd.high_speed_cmd
                 | o_cmd.fifteen_speed_select;
    a_wait_one: assert property (
        req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    a_wait_idle: assert property (!req && o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest dropped without a request");
    a_shut_gates: assert property (
        shut && $past(shut) |-> !o_output_enable && !o_cmd.forward_run_cmd
        && !o_cmd.reverse_run_cmd)
        else $error("output or start enabled during shutoff");
    a_coast_shut: assert property (shut |-> o_cmd.coast_stop)
        else $error("shutoff without coasting");
    a_vf_frozen: assert property (
        i_running && $past(i_running) && $past(i_running, 2) |-> $stable(o_cmd.vf_control))
        else $error("control method changed while running");
    a_cmd_readback: assert property (
        $past(i_avs_read) && $past(i_avs_address) == 5'h1c && !o_avs_waitrequest
        |-> o_avs_readdata == {5'h00, $past(o_cmd)})
        else $error("command word readback wrong");
    a_jog_first: assert property (jog [*2] |-> o_speed_source == SPD_JOG)
        else $error("jog not highest speed source");
    a_multi_next: assert property ((!jog && multi) [*2] |-> o_speed_source == SPD_MULTI)
        else $error("multi-speed not second speed source");
    a_input4_mask: assert property (
        o_cmd.input4_select && $past(o_cmd.input4_select) |-> !o_cmd.voltage_input_valid)
        else $error("voltage input valid with input4 selected");
    c_jog: cover property (o_speed_source == SPD_JOG);
    c_shut: cover property (shut);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind itfm_mapper itfm_mapper_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_running(i_running), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_cmd(o_cmd),
    .o_speed_source(o_speed_source), .o_output_enable(o_output_enable));

// ---- test/itfm_mapper_bench.sv ----
`timescale 1ns/10ps
module itfm_mapper_bench;
    import itfm_pkg::*;
    typedef struct { logic [13:0] code; int b; } itfm_row_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [4:0]  closed = 5'h00;
    logic        run = 1'b0;
    logic [4:0]  term;
    logic [31:0] rdata;
    logic [31:0] r;
    logic        wreq;
    logic        oen;
    logic        shut;
    logic [3:0]  idx;
    itfm_cmd_s   cmd;
    itfm_speed_e spd;
    int          miscompares = 0;
    int          n_compared = 0;
    itfm_row_s   rows [18] = '{'{0, 26}, '{1, 25}, '{2, 24}, '{3, 20}, '{4, 19}, '{5, 17},
        '{8, 15}, '{10, 14}, '{12, 13}, '{14, 12}, '{16, 11}, '{18, 10}, '{25, 7},
        '{37, 6}, '{62, 3}, '{65, 2}, '{66, 1}, '{67, 0}};
    always #20 clk = ~clk;
    itfm_contacts u_contacts (.i_clk(clk), .i_closed(closed), .o_terminal(term));
    itfm_mapper #(.DEBOUNCE_CYCLES(4)) dut (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_terminal(term), .i_running(run), .o_cmd(cmd), .o_speed_source(spd),
        .o_multi_speed_index(idx), .o_output_enable(oen));
    task close_out;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0) begin
            chk(wreq, 1'b0);
            close_out();
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task settle;
        repeat (16) @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        chk(1'b0, 1'b1);
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({wreq, oen, cmd.voltage_input_valid, cmd.run_enable_in}, 4'hf);
        bus(1'b0, 5'h04, 32'h0);
        chk(r, 32'h3c);
        bus(1'b0, 5'h00, 32'h0);
        chk(r, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, 5'h0c, {18'h0, rows[i].code});
            closed <= 5'h04;
            settle();
            chk(cmd[rows[i].b], 1'b1);
            closed <= 5'h00;
            settle();
            chk(cmd[rows[i].b], 1'b0);
        end
        bus(1'b1, 5'h0c, 32'h1);
        closed <= 5'h04;
        settle();
        chk({cmd.middle_speed_cmd, spd}, {1'b1, SPD_MULTI});
        bus(1'b1, 5'h0c, 32'h5);
        closed <= 5'h0c;
        settle();
        chk({spd, idx}, {SPD_JOG, 4'h2});
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b1, 5'h0c, 32'h0);
        closed <= 5'h04;
        settle();
        chk({cmd.low_speed_cmd, cmd.remote_clear}, 2'b01);
        bus(1'b1, 5'h10, 32'h7);
        closed <= 5'h00;
        settle();
        chk(cmd.thermal_relay_in, 1'b1);
        bus(1'b1, 5'h08, 32'h3c);
        bus(1'b0, 5'h08, 32'h0);
        chk(r, 32'h3d);
        bus(1'b0, 5'h03, 32'h0);
        chk(r, 32'h0);
        bus(1'b1, 5'h14, 32'h18);
        for (int k = 0; k < 12; k++) begin
            bus(1'b1, 5'h00, {15'h0, k[0], 5'h0, 3'((k / 4) * 2), 8'h0});
            closed <= {k[1], 4'h1};
            repeat (5) @(posedge clk);
            shut = (k < 4) ? (k[1] | k[0]) : (k < 8) ? !(k[1] & k[0]) : !(k[1] & !k[0]);
            chk(oen, !shut);
        end
        settle();
        chk({cmd.output_shutoff_in, cmd.coast_stop, cmd.forward_run_cmd, cmd.run_enable_in},
            4'hc);
        bus(1'b1, 5'h00, 32'h7000);
        closed <= 5'h10;
        settle();
        chk(cmd.panel_interlock_in, 1'b1);
        bus(1'b1, 5'h0c, 32'h12);
        run <= 1'b1;
        closed <= 5'h05;
        settle();
        chk({cmd.vf_control, cmd.second_function_select, oen}, 3'b011);
        run <= 1'b0;
        settle();
        chk({cmd.vf_control, cmd.forward_run_cmd}, 2'b11);
        bus(1'b0, 5'h1c, 32'h0);
        chk(r, 32'h0015_4420);
        bus(1'b1, 5'h0c, 32'h270f);
        settle();
        chk({cmd.second_function_select, cmd.vf_control}, 2'b00);
        bus(1'b0, 5'h0c, 32'h0);
        chk(r, 32'h270f);
        close_out();
    end
endmodule
